/* sdpc_host.sv */
`timescale 1ns/1ps
// ==========================================================
// host side register master
module sdpc_host
  import sdpc_pkg::*;
(
  input wire logic ref_clk,
  output logic [ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end

  // full-word strobes only: partial writes are left unexercised
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // a status read is what releases latched flags on the device
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

/* sdpc_pkg.sv */
package sdpc_pkg;
  // ==========================================================
  // clock and protection timing
  localparam int CLK_KHZ = 10000;
  localparam int T_ON_MS = 90;
  localparam int T_OFF_MS = 900;
  localparam int T_SINK_MS = 10;
  localparam int ON_CYC = T_ON_MS * CLK_KHZ;
  localparam int OFF_CYC = T_OFF_MS * CLK_KHZ;
  localparam int SINK_CYC = T_SINK_MS * CLK_KHZ;
  localparam int TMR_W = 24;

  // ==========================================================
  // register map
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 4'h4;
  localparam int CTRL_OUTEN_BIT = 0;
  localparam int CTRL_COMP_BIT = 1;
  localparam int CTRL_VSEL_LSB = 2;
  localparam int VSEL_W = 3;
  localparam int CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam int ST_OL = 0;
  localparam int ST_OT = 1;
  localparam int ST_SL = 2;
  localparam int ST_VL = 3;
  localparam int ST_PD = 4;
  localparam int STAT_W = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ==========================================================
  // synchronised comparator inputs
  localparam int IN_OL = 0;
  localparam int IN_OT = 1;
  localparam int IN_SL = 2;
  localparam int IN_VL = 3;
  localparam int IN_PD = 4;
  localparam int IN_LK = 5;
  localparam int IN_W = 6;

  typedef enum logic [1:0] {
    OL_IDLE = 2'b00,
    OL_ON = 2'b01,
    OL_OFF = 2'b10,
    OL_RETRY = 2'b11
  } sdpc_ol_e;
endpackage

/* sdpc_top.sv */
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module sdpc_top
  import sdpc_pkg::*;
#(
  parameter int ON_CYCLES = ON_CYC,
  parameter int OFF_CYCLES = OFF_CYC,
  parameter int SINK_CYCLES = SINK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic stageClk,
  input wire logic overloadDet,
  input wire logic overtempDet,
  input wire logic supplyLowDet,
  input wire logic outLowDet,
  input wire logic pulldownOcDet,
  input wire logic supplyLockout,
  output logic [VSEL_W-1:0] vselOut,
  output logic compOut,
  output logic boostEn,
  output logic linearEn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // input synchronisers
  wire [IN_W-1:0] rawIn;
  logic [IN_W-1:0] meta_ff;
  logic [IN_W-1:0] syn_ff;
  assign rawIn = {supplyLockout, pulldownOcDet, outLowDet,
                  supplyLowDet, overtempDet, overloadDet};

  generate
    for (genvar i = 0; i < IN_W; i++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
          meta_ff[i] <= 1'b0;
          syn_ff[i] <= 1'b0;
        end else if (ce) begin
          meta_ff[i] <= rawIn[i];
          syn_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

  wire olS = syn_ff[IN_OL];
  wire otS = syn_ff[IN_OT];
  wire slS = syn_ff[IN_SL];
  wire vlS = syn_ff[IN_VL];
  wire pdS = syn_ff[IN_PD];
  wire lockS = syn_ff[IN_LK];

  // ==========================================================
  // AXI4-Lite slave, one write and one read at a time
  logic awReady_ff;
  logic bValid_ff;
  logic [1:0] bResp_ff;
  logic [ADDR_W-1:0] wrAddr_ff;
  logic [31:0] wrData_ff;
  logic wrStrb0_ff;
  logic arReady_ff;
  logic rValid_ff;
  logic [1:0] rResp_ff;
  logic [31:0] rData_ff;
  logic [ADDR_W-1:0] rdAddr_ff;
  logic rdStat_ff;

  wire wrGo = s_axi_awvalid && s_axi_wvalid && !awReady_ff && !bValid_ff;
  wire wrTake = awReady_ff;
  wire wrHitCtrl = wrAddr_ff == CTRL_ADDR;
  wire wrHitStat = wrAddr_ff == STAT_ADDR;
  // lockout still answers, with an error, so the bus never hangs
  wire [1:0] wrResp = lockS ? RESP_SLVERR :
                      (wrHitCtrl || wrHitStat) ? RESP_OKAY : RESP_DECERR;
  wire wrCtrl = wrTake && wrHitCtrl && wrStrb0_ff && !lockS;

  wire rdGo = s_axi_arvalid && !arReady_ff && !rValid_ff;
  wire rdTake = arReady_ff;
  wire rdHitCtrl = rdAddr_ff == CTRL_ADDR;
  wire rdHitStat = rdAddr_ff == STAT_ADDR;
  wire [1:0] rdResp = lockS ? RESP_SLVERR :
                      (rdHitCtrl || rdHitStat) ? RESP_OKAY : RESP_DECERR;
  wire statRd = rValid_ff && s_axi_rready && rdStat_ff;
  wire [31:0] rdMux;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      awReady_ff <= 1'b0;
      bValid_ff <= 1'b0;
      bResp_ff <= RESP_OKAY;
      wrAddr_ff <= '0;
      wrData_ff <= '0;
      wrStrb0_ff <= 1'b0;
    end else if (ce) begin
      awReady_ff <= wrGo;
      if (wrGo) begin
        wrAddr_ff <= s_axi_awaddr;
        wrData_ff <= s_axi_wdata;
        wrStrb0_ff <= s_axi_wstrb[0];
      end
      if (wrTake) begin
        bValid_ff <= 1'b1;
        bResp_ff <= wrResp;
      end else if (s_axi_bready) begin
        bValid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      arReady_ff <= 1'b0;
      rValid_ff <= 1'b0;
      rResp_ff <= RESP_OKAY;
      rData_ff <= '0;
      rdAddr_ff <= '0;
      rdStat_ff <= 1'b0;
    end else if (ce) begin
      arReady_ff <= rdGo;
      if (rdGo) begin
        rdAddr_ff <= s_axi_araddr;
      end
      if (rdTake) begin
        rValid_ff <= 1'b1;
        rResp_ff <= rdResp;
        rData_ff <= rdMux;
        rdStat_ff <= rdHitStat && !lockS;
      end else if (s_axi_rready) begin
        rValid_ff <= 1'b0;
        rdStat_ff <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awReady_ff;
  assign s_axi_wready = awReady_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_arready = arReady_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rresp = rResp_ff;
  assign s_axi_rdata = rData_ff;

  // ==========================================================
  // control register
  logic [CTRL_W-1:0] ctrl_ff;
  wire [CTRL_W-1:0] nxt_ctrl = lockS ? CTRL_RST :
                               wrCtrl ? wrData_ff[CTRL_W-1:0] : ctrl_ff;
  wire ctrlOutEn = ctrl_ff[CTRL_OUTEN_BIT];

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ctrl_ff <= CTRL_RST;
    end else if (ce) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  logic [VSEL_W-1:0] vsel_ff;
  logic comp_ff;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      vsel_ff <= '0;
      comp_ff <= 1'b0;
    end else if (ce) begin
      vsel_ff <= nxt_ctrl[CTRL_VSEL_LSB +: VSEL_W];
      comp_ff <= nxt_ctrl[CTRL_COMP_BIT];
    end
  end
  assign vselOut = vsel_ff;
  assign compOut = comp_ff;

  // ==========================================================
  // overload on/off retry
  sdpc_ol_e olState_ff;
  sdpc_ol_e nxt_olState;
  logic [TMR_W-1:0] tmr_ff;
  logic olSeen_ff;
  wire onEnd = tmr_ff == TMR_W'(ON_CYCLES - 1);
  wire offEnd = tmr_ff == TMR_W'(OFF_CYCLES - 1);
  wire outAllowed = ctrlOutEn && !lockS && !otS;
  wire olStart = olState_ff == OL_IDLE && olS && outAllowed;
  wire olBusy = olState_ff != OL_IDLE;

  always_comb begin
    nxt_olState = olState_ff;
    unique case (olState_ff)
      OL_IDLE: if (olStart) nxt_olState = OL_ON;
      OL_ON: if (onEnd) nxt_olState = OL_OFF;
      OL_OFF: if (offEnd) nxt_olState = OL_RETRY;
      OL_RETRY: begin
        if (onEnd) begin
          nxt_olState = (olSeen_ff || olS) ? OL_OFF : OL_IDLE;
        end
      end
    endcase
    // host disable or lockout abandons the cycle
    if (!ctrlOutEn || lockS) begin
      nxt_olState = OL_IDLE;
    end
  end

  wire tmrClr = nxt_olState != olState_ff || olState_ff == OL_IDLE;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      olState_ff <= OL_IDLE;
      tmr_ff <= '0;
      olSeen_ff <= 1'b0;
    end else if (ce) begin
      olState_ff <= nxt_olState;
      tmr_ff <= tmrClr ? '0 : tmr_ff + 1'b1;
      olSeen_ff <= (olState_ff == OL_RETRY && !tmrClr) ? (olSeen_ff || olS) : 1'b0;
    end
  end

  // ==========================================================
  // pull-down overcurrent persistence
  logic [TMR_W-1:0] pdCnt_ff;
  wire pdSet = pdS && pdCnt_ff == TMR_W'(SINK_CYCLES);
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pdCnt_ff <= '0;
    end else if (ce) begin
      if (!pdS) begin
        pdCnt_ff <= '0;
      end else if (!pdSet) begin
        pdCnt_ff <= pdCnt_ff + 1'b1;
      end
    end
  end

  // ==========================================================
  // status flags; a set in the clearing cycle wins
  logic olFlag_ff;
  logic otFlag_ff;
  logic slFlag_ff;
  logic vlFlag_ff;
  logic pdFlag_ff;
  wire stageEn = outAllowed && olState_ff != OL_OFF;
  wire nxt_olFlag = olStart || (olFlag_ff && !(statRd && !olBusy));
  wire nxt_otFlag = otS || (otFlag_ff && !statRd);
  wire nxt_slFlag = slS || (slFlag_ff && !statRd);
  wire nxt_vlFlag = stageEn && vlS;
  wire nxt_pdFlag = pdSet || (pdFlag_ff && !statRd);
  wire [STAT_W-1:0] statVec;
  assign statVec[ST_OL] = olFlag_ff;
  assign statVec[ST_OT] = otFlag_ff;
  assign statVec[ST_SL] = slFlag_ff;
  assign statVec[ST_VL] = vlFlag_ff;
  assign statVec[ST_PD] = pdFlag_ff;
  assign rdMux = lockS ? 32'h0000_0000 :
                      rdHitStat ? {{(32-STAT_W){1'b0}}, statVec} :
                      rdHitCtrl ? {{(32-CTRL_W){1'b0}}, ctrl_ff} : 32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      olFlag_ff <= 1'b0;
      otFlag_ff <= 1'b0;
      slFlag_ff <= 1'b0;
      vlFlag_ff <= 1'b0;
      pdFlag_ff <= 1'b0;
    end else if (ce) begin
      olFlag_ff <= nxt_olFlag;
      otFlag_ff <= nxt_otFlag;
      slFlag_ff <= nxt_slFlag;
      vlFlag_ff <= nxt_vlFlag;
      pdFlag_ff <= nxt_pdFlag;
    end
  end

  // ==========================================================
  // power stage enables, crossed to the stage clock
  logic stageReq_ff;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stageReq_ff <= 1'b0;
    end else if (ce) begin
      stageReq_ff <= stageEn;
    end
  end

  logic lnkRstMeta_ff;
  logic lnkRst_b_ff;
  logic lnkMeta_ff;
  logic lnkSync_ff;
  logic boost_ff;
  logic linear_ff;
  always_ff @(posedge stageClk) begin
    lnkRstMeta_ff <= rst_b;
    lnkRst_b_ff <= lnkRstMeta_ff;
  end
  always_ff @(posedge stageClk) begin
    if (!lnkRst_b_ff) begin
      lnkMeta_ff <= 1'b0;
      lnkSync_ff <= 1'b0;
      boost_ff <= 1'b0;
      linear_ff <= 1'b0;
    end else begin
      lnkMeta_ff <= stageReq_ff;
      lnkSync_ff <= lnkMeta_ff;
      boost_ff <= lnkSync_ff;
      linear_ff <= lnkSync_ff;
    end
  end
  assign boostEn = boost_ff;
  assign linearEn = linear_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence sStatusRead;
    statRd;
  endsequence
  sequence sOverloadStart;
    ce && olStart;
  endsequence

  a_stat_upper_zero: assert property (rValid_ff && rdStat_ff |->
    rData_ff[31:STAT_W] == '0) else $error("status upper bits set");
  a_ol_flag_hold: assert property (olFlag_ff && !statRd |=> olFlag_ff)
    else $error("overload flag dropped without read");
  a_outlow_live: assert property (ce && stageEn && vlS |=> vlFlag_ff)
    else $error("output-low flag missing");
  a_pd_timeout: assert property ($rose(pdFlag_ff) |->
    $past(pdCnt_ff) == TMR_W'(SINK_CYCLES)) else $error("pull-down flag early");
  a_supply_low: assert property (ce && slS |=> slFlag_ff)
    else $error("supply-low flag missing");
  a_lock_ctrl: assert property (ce && lockS |=> ctrl_ff == CTRL_RST && !stageReq_ff)
    else $error("control not cleared in lockout");
  a_ol_entry: assert property (sOverloadStart |=>
    olState_ff == OL_ON && olFlag_ff && tmr_ff == '0) else $error("overload entry wrong");
  a_ol_off_gate: assert property (ce && olState_ff == OL_OFF |=> !stageReq_ff)
    else $error("output on during off-window");
  a_ot_stages: assert property (ce && otS |=> !stageReq_ff && otFlag_ff)
    else $error("stages on in overtemperature");
  a_read_clear: assert property (ce && !otS ##0 sStatusRead |=>
    !otFlag_ff) else $error("overtemp flag not cleared by read");
endmodule

/* sdpc_top_tb.sv */
`timescale 1ns/1ps
// ==========================================================
// bench
module sdpc_top_tb;
  import sdpc_pkg::*;
  logic ref_clk, rst_b, ce, stageClk;
  logic [IN_W-1:0] det;
  logic [VSEL_W-1:0] vselOut;
  logic compOut, boostEn, linearEn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire logic overloadDet = det[IN_OL];
  wire logic overtempDet = det[IN_OT];
  wire logic supplyLowDet = det[IN_SL];
  wire logic outLowDet = det[IN_VL];
  wire logic pulldownOcDet = det[IN_PD];
  wire logic supplyLockout = det[IN_LK];
  int errorCnt = 0;
  int cmpCount = 0;
  logic [31:0] rdData;
  logic [1:0] resp;

  // short windows keep the run small
  sdpc_top #(.ON_CYCLES(20), .OFF_CYCLES(50), .SINK_CYCLES(10)) sdpc_top_i (.*);
  sdpc_host sdpc_host_i (.*);

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    stageClk = 1'b0;
    #17;
    forever #40 stageClk = ~stageClk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmpCount++;
    if (s !== e) begin
      errorCnt++;
      $display("ERROR %s expected %0h seen %0h", n, e, s);
    end
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string n);
    sdpc_host_i.rd(a, rdData, resp);
    chk({n, " resp"}, RESP_OKAY, resp);
    chk(n, e, rdData);
  endtask

  task automatic wrc(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] e);
    sdpc_host_i.wr(a, d, resp);
    chk("write resp", e, resp);
  endtask

  // set a cause, read while present, remove, read latched, read cleared
  task automatic latch(input int b, input int hold, input logic [1:0] stg);
    det[b] <= 1'b1;
    cyc(hold);
    chk("stage during fault", stg, {boostEn, linearEn});
    rdc(STAT_ADDR, 32'h1 << b, "flag while present");
    det[b] <= 1'b0;
    cyc(4);
    rdc(STAT_ADDR, 32'h1 << b, "flag after cause");
    chk("stage after fault", 2'h3, {boostEn, linearEn});
    rdc(STAT_ADDR, 32'h0, "flag released");
  endtask

  task automatic endSim;
    $display("compares %0d errors %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errorCnt++;
    endSim();
  end

  initial begin
    det = '0;
    rst_b = 1'b0;
    ce = 1'b1;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    cyc(2);
    rdc(STAT_ADDR, 32'h0, "status");
    rdc(CTRL_ADDR, 32'h0, "ctrl");
    wrc(CTRL_ADDR, 32'h17, RESP_OKAY);
    cyc(8);
    chk("vsel", 3'h5, vselOut);
    chk("comp", 1'b1, compOut);
    sdpc_host_i.rd(4'h8, rdData, resp);
    chk("unmapped read", RESP_DECERR, resp);
    chk("unmapped data", 32'h0, rdData);
    wrc(4'hC, 32'h1, RESP_DECERR);
    @(posedge ref_clk);
    latch(IN_SL, 8, 2'h3);
    @(posedge ref_clk);
    latch(IN_OT, 12, 2'h0);
    @(posedge ref_clk);
    // exactly the limit: one cycle more would latch the flag
    det[IN_PD] <= 1'b1;
    cyc(10);
    det[IN_PD] <= 1'b0;
    cyc(4);
    rdc(STAT_ADDR, 32'h0, "short sink");
    latch(IN_PD, 20, 2'h3);
    det[IN_VL] <= 1'b1;
    cyc(4);
    rdc(STAT_ADDR, 32'h1 << ST_VL, "output low");
    det[IN_VL] <= 1'b0;
    cyc(4);
    rdc(STAT_ADDR, 32'h0, "output ok");
    // overload: checkpoints sit mid-window to absorb crossing latency
    det[IN_OL] <= 1'b1;
    cyc(15);
    chk("on window", 1'b1, boostEn);
    cyc(15);
    chk("off window", 1'b0, boostEn);
    rdc(STAT_ADDR, 32'h1 << ST_OL, "overload");
    cyc(24);
    chk("still off", 1'b0, boostEn);
    cyc(24);
    chk("retry on", 1'b1, boostEn);
    cyc(20);
    chk("off again", 1'b0, boostEn);
    det[IN_OL] <= 1'b0;
    rdc(STAT_ADDR, 32'h1 << ST_OL, "overload kept");
    cyc(70);
    chk("resumed", 1'b1, boostEn);
    rdc(STAT_ADDR, 32'h1 << ST_OL, "overload latched");
    rdc(STAT_ADDR, 32'h0, "overload released");
    det[IN_LK] <= 1'b1;
    cyc(6);
    wrc(CTRL_ADDR, 32'h1D, RESP_SLVERR);
    sdpc_host_i.rd(CTRL_ADDR, rdData, resp);
    chk("lockout read", RESP_SLVERR, resp);
    chk("lockout data", 32'h0, rdData);
    cyc(6);
    chk("lockout vsel", 3'h0, vselOut);
    chk("lockout stage", 2'h0, {boostEn, linearEn});
    det[IN_LK] <= 1'b0;
    cyc(6);
    wrc(CTRL_ADDR, 32'h09, RESP_OKAY);
    cyc(8);
    chk("vsel after", 3'h2, vselOut);
    chk("comp after", 1'b0, compOut);
    rdc(CTRL_ADDR, 32'h09, "ctrl after");
    // lockout raised and dropped while frozen must never be seen
    ce <= 1'b0;
    det[IN_LK] <= 1'b1;
    cyc(6);
    det[IN_LK] <= 1'b0;
    ce <= 1'b1;
    cyc(6);
    chk("frozen vsel", 3'h2, vselOut);
    endSim();
  end
endmodule
